// *** mpu_pkg.sv ***
package mpu_pkg;

    // ------------------------------------------------------------
    // Link widths and I/O map
    // ------------------------------------------------------------
    localparam int IO_ADDR_W = 16;
    localparam logic [15:0] PIXEL_MASK_PORT = 16'h03C6;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    localparam logic [2:0] SEQ_READS = 3'h4;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int MODE_CLK_BIT = 5;
    localparam int MODE_MIX_BIT = 4;
    localparam int MIX_SEL_BIT = 15;
    localparam logic [1:0] EXT_PREFIX = 2'h3;
    localparam logic [4:0] CODE_555 = 5'h00;
    localparam logic [4:0] CODE_MIX = 5'h10;
    localparam logic [4:0] CODE_565 = 5'h01;
    localparam logic [4:0] CODE_888 = 5'h05;
    localparam logic [4:0] CODE_POWER = 5'h06;
    localparam logic [4:0] CODE_POWER_ALT = 5'h07;
    localparam logic [4:0] CODE_GRAY = 5'h08;
    localparam logic [4:0] CODE_332 = 5'h09;

    // ------------------------------------------------------------
    // Host command registers
    // ------------------------------------------------------------
    localparam int CMD_ADDR_W = 4;
    localparam logic [3:0] HOST_MODE_REQ = 4'h0;
    localparam logic [3:0] HOST_MASK = 4'h1;
    localparam logic [3:0] HOST_STATUS = 4'h2;
    localparam logic [3:0] HOST_LAST_READ = 4'h3;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_CLK2_BIT = 1;

    typedef enum logic [2:0] {
        MPU_PALETTE,
        MPU_555,
        MPU_MIX,
        MPU_565,
        MPU_888,
        MPU_332,
        MPU_GRAY,
        MPU_POWER_DOWN
    } mpu_mode_type;

    function automatic mpu_mode_type mpu_decode(input logic [7:0] code);
        mpu_mode_type m;
        m = MPU_PALETTE;
        if (code[7:6] == EXT_PREFIX)
        begin
            case (code[4:0])
                CODE_555: m = MPU_555;
                CODE_MIX: m = MPU_MIX;
                CODE_565: m = MPU_565;
                CODE_888: m = MPU_888;
                CODE_POWER: m = MPU_POWER_DOWN;
                CODE_POWER_ALT: m = MPU_POWER_DOWN;
                CODE_GRAY: m = MPU_GRAY;
                CODE_332: m = MPU_332;
                default: m = MPU_PALETTE;
            endcase
        end
        return m;
    endfunction

endpackage

// *** mpu_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mpu_link_if;
    import mpu_pkg::*;
    logic [IO_ADDR_W-1:0] io_addr;
    logic [7:0] io_wdata;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_rdata;
    logic [7:0] pix_data;
    logic pix_blank_n;

    modport device (
        input io_addr, io_wdata, io_wr, io_rd, pix_data, pix_blank_n,
        output io_rdata
    );
    modport host (
        output io_addr, io_wdata, io_wr, io_rd, pix_data, pix_blank_n,
        input io_rdata
    );
endinterface
`default_nettype wire

// *** mpu_pixel_format.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpu_pixel_format
    import mpu_pkg::*;
(
    input wire mpu_pkg::mpu_mode_type mode_in,
    input wire logic [23:0] word_in,
    input wire logic [7:0] mask_in,
    output logic [7:0] red_out,
    output logic [7:0] green_out,
    output logic [7:0] blue_out,
    output logic [7:0] lut_index_out,
    output logic lut_bypass_out
);
    // Narrow channels are left-justified so full scale stays near full
    always_comb
    begin
        red_out = 8'h00;
        green_out = 8'h00;
        blue_out = 8'h00;
        lut_index_out = 8'h00;
        lut_bypass_out = 1'b1;
        case (mode_in)
            MPU_555:
            begin
                red_out = {word_in[14:10], 3'h0};
                green_out = {word_in[9:5], 3'h0};
                blue_out = {word_in[4:0], 3'h0};
            end
            MPU_MIX:
            begin
                if (word_in[MIX_SEL_BIT])
                begin
                    lut_bypass_out = 1'b0;
                    lut_index_out = word_in[7:0] & mask_in;
                end
                else
                begin
                    red_out = {word_in[14:10], 3'h0};
                    green_out = {word_in[9:5], 3'h0};
                    blue_out = {word_in[4:0], 3'h0};
                end
            end
            MPU_565:
            begin
                red_out = {word_in[15:11], 3'h0};
                green_out = {word_in[10:5], 2'h0};
                blue_out = {word_in[4:0], 3'h0};
            end
            MPU_888:
            begin
                red_out = word_in[23:16];
                green_out = word_in[15:8];
                blue_out = word_in[7:0];
            end
            MPU_332:
            begin
                red_out = {word_in[7:5], 5'h00};
                green_out = {word_in[4:2], 5'h00};
                blue_out = {word_in[1:0], 6'h00};
            end
            MPU_GRAY:
            begin
                red_out = word_in[7:0];
                green_out = word_in[7:0];
                blue_out = word_in[7:0];
            end
            MPU_PALETTE:
            begin
                lut_bypass_out = 1'b0;
                lut_index_out = word_in[7:0] & mask_in;
            end
            default:
            begin
                lut_bypass_out = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// *** mpu_dac_device.sv ***
//Contract
// - Reset clears mode register; palette mode.
// - Host reads mask port four times consecutively.
// - After fourth read, next access hits mode.
// - Other-address access zeroes read counter.
// - E0/C0 selects 5-5-5; F0/D0 mixed.
// - E1 selects 5-6-5 direct color.
// - E5 selects 8-8-8 direct color.
// - C6 power-down, C8 gray, C9 3-3-2.
// - Mode bit 5 picks clocking mode.
// - Bit 4 enables per-pixel bit-15 select.
// - Mixed: bit15 zero direct, one palette.
// - 5-5-5 uses bits 14:0, ignores 15.
// - Low byte first, captured from unblanked edge.
// - 5-5-5 and 5-6-5 modes bypass lookup table.
// - 5-6-5 red 15:11, green 10:5, blue 4:0.
// - 8-8-8 bytes arrive blue, green, red.
// - 3-3-2 red 7:5, green 4:2, blue 1:0.
// - Grayscale uses byte as gray level.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mpu_dac_device
    import mpu_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    mpu_link_if.device link,
    output logic [7:0] red_out,
    output logic [7:0] green_out,
    output logic [7:0] blue_out,
    output logic [7:0] lut_index_out,
    output logic lut_bypass_out,
    output logic pixel_valid_out,
    output logic power_down_out,
    output logic clock_mode2_out,
    output logic [7:0] mode_out
);
    import mpu_pkg::*;

    // ------------------------------------------------------------
    // Port access state
    // ------------------------------------------------------------
    logic [7:0] mode_reg;
    logic [7:0] next_mode_reg;
    logic [7:0] mask_reg;
    logic [7:0] next_mask_reg;
    logic [2:0] read_count;
    logic [2:0] next_read_count;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic at_port;
    logic redirect;

    assign at_port = (link.io_addr == PIXEL_MASK_PORT);
    assign redirect = (read_count == SEQ_READS);

    always_comb
    begin
        next_mode_reg = mode_reg;
        next_mask_reg = mask_reg;
        next_read_count = read_count;
        next_rdata = 8'h00;
        if (link.io_wr || link.io_rd)
        begin
            if (!at_port)
            begin
                next_read_count = 3'h0;
            end
            else if (redirect)
            begin
                // One access only is redirected, then counting restarts
                next_read_count = 3'h0;
                if (link.io_wr)
                begin
                    next_mode_reg = link.io_wdata;
                end
                else
                begin
                    next_rdata = mode_reg;
                end
            end
            else if (link.io_rd)
            begin
                next_rdata = mask_reg;
                next_read_count = read_count + 3'h1;
            end
            else
            begin
                // A write breaks the run of reads
                next_mask_reg = link.io_wdata;
                next_read_count = 3'h0;
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            mode_reg <= MODE_RESET;
            mask_reg <= MASK_RESET;
            read_count <= 3'h0;
            rdata <= 8'h00;
        end
        else
        begin
            mode_reg <= next_mode_reg;
            mask_reg <= next_mask_reg;
            read_count <= next_read_count;
            rdata <= next_rdata;
        end
    end

    assign link.io_rdata = rdata;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    mpu_mode_type mode;
    logic [1:0] last_idx;

    assign mode = mpu_decode(mode_reg);

    always_comb
    begin
        case (mode)
            MPU_555: last_idx = 2'h1;
            MPU_MIX: last_idx = 2'h1;
            MPU_565: last_idx = 2'h1;
            MPU_888: last_idx = 2'h2;
            default: last_idx = 2'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    logic [1:0] byte_idx;
    logic [1:0] next_byte_idx;
    logic [15:0] held;
    logic [15:0] next_held;
    logic [23:0] word;
    logic done;

    // Final byte joins the held lower bytes without an extra cycle
    always_comb
    begin
        case (byte_idx)
            2'h0: word = {16'h0000, link.pix_data};
            2'h1: word = {8'h00, link.pix_data, held[7:0]};
            default: word = {link.pix_data, held};
        endcase
    end

    assign done = link.pix_blank_n && (byte_idx == last_idx);

    always_comb
    begin
        next_byte_idx = byte_idx;
        next_held = held;
        if (!link.pix_blank_n)
        begin
            next_byte_idx = 2'h0;
        end
        else if (done)
        begin
            next_byte_idx = 2'h0;
        end
        else
        begin
            next_byte_idx = byte_idx + 2'h1;
            if (byte_idx == 2'h0)
            begin
                next_held[7:0] = link.pix_data;
            end
            else
            begin
                next_held[15:8] = link.pix_data;
            end
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            byte_idx <= 2'h0;
            held <= 16'h0000;
        end
        else
        begin
            byte_idx <= next_byte_idx;
            held <= next_held;
        end
    end

    // ------------------------------------------------------------
    // Color output
    // ------------------------------------------------------------
    logic [7:0] fmt_red;
    logic [7:0] fmt_green;
    logic [7:0] fmt_blue;
    logic [7:0] fmt_index;
    logic fmt_bypass;

    mpu_pixel_format u_format (
        .mode_in(mode),
        .word_in(word),
        .mask_in(mask_reg),
        .red_out(fmt_red),
        .green_out(fmt_green),
        .blue_out(fmt_blue),
        .lut_index_out(fmt_index),
        .lut_bypass_out(fmt_bypass)
    );

    logic [7:0] next_red;
    logic [7:0] next_green;
    logic [7:0] next_blue;
    logic [7:0] next_index;
    logic next_bypass;
    logic next_valid;
    logic powered_down;

    assign powered_down = (mode == MPU_POWER_DOWN);

    // Outside power-down, outputs hold the last pixel between completions
    always_comb
    begin
        next_red = red_out;
        next_green = green_out;
        next_blue = blue_out;
        next_index = lut_index_out;
        next_bypass = lut_bypass_out;
        next_valid = 1'b0;
        if (powered_down)
        begin
            next_red = 8'h00;
            next_green = 8'h00;
            next_blue = 8'h00;
            next_index = 8'h00;
            next_bypass = 1'b1;
        end
        else if (done)
        begin
            next_red = fmt_red;
            next_green = fmt_green;
            next_blue = fmt_blue;
            next_index = fmt_index;
            next_bypass = fmt_bypass;
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            red_out <= 8'h00;
            green_out <= 8'h00;
            blue_out <= 8'h00;
            lut_index_out <= 8'h00;
            lut_bypass_out <= 1'b0;
            pixel_valid_out <= 1'b0;
            power_down_out <= 1'b0;
            clock_mode2_out <= 1'b0;
            mode_out <= MODE_RESET;
        end
        else
        begin
            red_out <= next_red;
            green_out <= next_green;
            blue_out <= next_blue;
            lut_index_out <= next_index;
            lut_bypass_out <= next_bypass;
            pixel_valid_out <= next_valid;
            power_down_out <= powered_down;
            clock_mode2_out <= next_mode_reg[MODE_CLK_BIT];
            mode_out <= next_mode_reg;
        end
    end
endmodule
`default_nettype wire

// *** mpu_dac_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpu_dac_host
    import mpu_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    mpu_link_if.host link,
    input wire logic [CMD_ADDR_W-1:0] cmd_addr_in,
    input wire logic [7:0] cmd_wdata_in,
    input wire logic cmd_wr_in,
    input wire logic cmd_rd_in,
    output logic [7:0] cmd_rdata_out,
    input wire logic [7:0] pixel_data_in,
    input wire logic pixel_blank_n_in
);
    import mpu_pkg::*;

    // ------------------------------------------------------------
    // Unlock sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {HS_IDLE, HS_READ, HS_WRITE} mpu_host_state_type;

    mpu_host_state_type state;
    mpu_host_state_type next_state;
    logic [2:0] reads;
    logic [2:0] next_reads;
    logic [7:0] code;
    logic [7:0] next_code;
    logic [7:0] last_read;
    logic [7:0] next_last_read;
    logic rd_pending;
    logic [7:0] next_rdata;
    logic [IO_ADDR_W-1:0] next_addr;
    logic [7:0] next_wdata;
    logic next_wr;
    logic next_rd;

    always_comb
    begin
        next_state = state;
        next_reads = reads;
        next_code = code;
        next_last_read = rd_pending ? link.io_rdata : last_read;
        next_addr = link.io_addr;
        next_wdata = link.io_wdata;
        next_wr = 1'b0;
        next_rd = 1'b0;
        case (state)
            HS_IDLE:
            begin
                // Orders arriving while busy are dropped
                if (cmd_wr_in && cmd_addr_in == HOST_MODE_REQ)
                begin
                    next_code = cmd_wdata_in;
                    next_reads = 3'h0;
                    next_state = HS_READ;
                end
                else if (cmd_wr_in && cmd_addr_in == HOST_MASK)
                begin
                    next_addr = PIXEL_MASK_PORT;
                    next_wdata = cmd_wdata_in;
                    next_wr = 1'b1;
                end
            end
            HS_READ:
            begin
                // Back-to-back reads: nothing else may slip between
                next_addr = PIXEL_MASK_PORT;
                next_rd = 1'b1;
                next_reads = reads + 3'h1;
                if (reads + 3'h1 == SEQ_READS)
                begin
                    next_state = HS_WRITE;
                end
            end
            HS_WRITE:
            begin
                next_addr = PIXEL_MASK_PORT;
                next_wdata = code;
                next_wr = 1'b1;
                next_state = HS_IDLE;
            end
            default:
            begin
                next_state = HS_IDLE;
            end
        endcase
        next_rdata = 8'h00;
        if (cmd_rd_in)
        begin
            case (cmd_addr_in)
                HOST_MODE_REQ: next_rdata = code;
                HOST_STATUS: next_rdata = {6'h00,
                    code[MODE_CLK_BIT], state != HS_IDLE};
                HOST_LAST_READ: next_rdata = last_read;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            state <= HS_IDLE;
            reads <= 3'h0;
            code <= MODE_RESET;
            last_read <= 8'h00;
            rd_pending <= 1'b0;
            cmd_rdata_out <= 8'h00;
            link.io_addr <= '0;
            link.io_wdata <= 8'h00;
            link.io_wr <= 1'b0;
            link.io_rd <= 1'b0;
            link.pix_data <= 8'h00;
            link.pix_blank_n <= 1'b0;
        end
        else
        begin
            state <= next_state;
            reads <= next_reads;
            code <= next_code;
            last_read <= next_last_read;
            rd_pending <= link.io_rd;
            cmd_rdata_out <= next_rdata;
            link.io_addr <= next_addr;
            link.io_wdata <= next_wdata;
            link.io_wr <= next_wr;
            link.io_rd <= next_rd;
            link.pix_data <= pixel_data_in;
            link.pix_blank_n <= pixel_blank_n_in;
        end
    end
endmodule
`default_nettype wire

// *** mpu_link_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpu_link_assertions
    import mpu_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [mpu_pkg::IO_ADDR_W-1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] pix_data,
    input wire logic pix_blank_n
);
    import mpu_pkg::*;
    // ----------------------------------------
    // Shadow of the port state the device keeps
    // ----------------------------------------
    logic [2:0] rd_cnt, next_rd_cnt;
    logic [7:0] mask_q, next_mask_q, mode_q, next_mode_q;
    logic at_port;
    logic armed;
    assign at_port = io_addr == PIXEL_MASK_PORT;
    assign armed = rd_cnt == SEQ_READS;
    always_comb
    begin
        next_rd_cnt = rd_cnt;
        next_mask_q = mask_q;
        next_mode_q = mode_q;
        if (io_wr || io_rd)
        begin
            if (!at_port)
                next_rd_cnt = 3'h0;
            else if (armed)
            begin
                next_rd_cnt = 3'h0;
                if (io_wr)
                    next_mode_q = io_wdata;
            end
            else if (io_rd)
                next_rd_cnt = rd_cnt + 3'h1;
            else
            begin
                next_rd_cnt = 3'h0;
                next_mask_q = io_wdata;
            end
        end
    end
    always_ff @(posedge sys_clk_in)
    begin
        if (!reset_n_in)
        begin
            rd_cnt <= 3'h0;
            mask_q <= MASK_RESET;
            mode_q <= MODE_RESET;
        end
        else
        begin
            rd_cnt <= next_rd_cnt;
            mask_q <= next_mask_q;
            mode_q <= next_mode_q;
        end
    end
    // ----------------------------------------
    // Port properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    rw_exclusive_a: assert property (!(io_wr && io_rd))
        else $error("read and write strobes high together");
    rdata_idle_a: assert property (!io_rd |=> io_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    mask_read_a: assert property (io_rd && at_port && !armed
        |=> io_rdata == mask_q) else $error("mask read wrong value");
    mode_read_a: assert property (io_rd && at_port && armed
        |=> io_rdata == mode_q) else $error("mode read wrong value");
    read_run_a: assert property ($rose(io_rd)
        |-> io_rd [*4] ##1 io_wr) else $error("unlock run not four reads");
    armed_write_a: assert property (armed |-> io_wr && at_port)
        else $error("armed port not followed by a mode write");
    read_addr_a: assert property (io_rd |-> at_port)
        else $error("read away from the mask port");
    write_pulse_a: assert property (io_wr |=> !io_wr && !io_rd)
        else $error("write not a single strobe");
    frame_c: cover property (pix_blank_n ##1
        !pix_blank_n && pix_data != 8'h00);
endmodule
`default_nettype wire

// *** tb_multimode_palette_pixel_unpacker.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_multimode_palette_pixel_unpacker;
    import mpu_pkg::*;
    logic sys_clk_in, reset_n_in, cmd_wr, cmd_rd, blank_n;
    logic [3:0] cmd_addr;
    logic [7:0] cmd_wdata, cmd_rdata, pix, red, green, blue, idx, mode, mode2;
    logic byp, valid, pdn, clk2;
    int mismatches;
    int num_checks;
    mpu_link_if link ();
    mpu_link_if link2 ();
    mpu_dac_host mpu_dac_host_i (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .link(link.host), .cmd_addr_in(cmd_addr),
        .cmd_wdata_in(cmd_wdata), .cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd),
        .cmd_rdata_out(cmd_rdata), .pixel_data_in(pix),
        .pixel_blank_n_in(blank_n));
    mpu_dac_device mpu_dac_device_i (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .link(link.device), .red_out(red),
        .green_out(green), .blue_out(blue), .lut_index_out(idx),
        .lut_bypass_out(byp), .pixel_valid_out(valid),
        .power_down_out(pdn), .clock_mode2_out(clk2), .mode_out(mode));
    // Second device faces the bench directly so port misuse can be driven
    mpu_dac_device mpu_dac_device_i2 (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .link(link2.device), .red_out(),
        .green_out(), .blue_out(), .lut_index_out(), .lut_bypass_out(),
        .pixel_valid_out(), .power_down_out(), .clock_mode2_out(),
        .mode_out(mode2));
    mpu_link_assertions mpu_link_assertions_i (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .io_addr(link.io_addr),
        .io_wdata(link.io_wdata), .io_wr(link.io_wr), .io_rd(link.io_rd),
        .io_rdata(link.io_rdata), .pix_data(link.pix_data),
        .pix_blank_n(link.pix_blank_n));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e,
        input logic [7:0] s);
        num_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmd(input logic wr, input logic [3:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk_in);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= wr;
        cmd_rd <= !wr;
        @(posedge sys_clk_in);
        cmd_wr <= 1'b0;
        cmd_rd <= 1'b0;
        #1 q = cmd_rdata;
    endtask
    task automatic set_mode(input logic [7:0] code);
        logic [7:0] s;
        int n;
        cmd(1'b1, HOST_MODE_REQ, code, s);
        s = 8'h01;
        for (n = 0; n < 40 && s[STATUS_BUSY_BIT] !== 1'b0; n++)
            cmd(1'b0, HOST_STATUS, 8'h00, s);
        if (n == 40)
        begin
            mismatches++;
            stop_test();
        end
        cmd(1'b0, HOST_MODE_REQ, 8'h00, s);
        chk("code readback", code, s);
        cmd(1'b0, HOST_STATUS, 8'h00, s);
        chk("status", {6'h00, code[MODE_CLK_BIT], 1'b0}, s);
        repeat (2) @(posedge sys_clk_in);
        #1 chk("mode", code, mode);
        chk("clock mode", {7'h0, code[5]}, {7'h0, clk2});
    endtask
    // Bytes leave low byte first; data toggles once blanked
    task automatic send(input logic [23:0] w, input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge sys_clk_in);
            blank_n <= 1'b1;
            pix <= w[8*i +: 8];
        end
        @(posedge sys_clk_in);
        blank_n <= 1'b0;
        pix <= ~pix;
        #1;
        for (i = 0; i < 10 && valid !== 1'b1; i++)
            @(posedge sys_clk_in) #1;
        if (i == 10)
        begin
            mismatches++;
            stop_test();
        end
        @(posedge sys_clk_in) #1;
        chk("valid pulse", 8'h00, {7'h0, valid});
    endtask
    task automatic rgb(input logic [7:0] r, g, b, input logic y);
        chk("red", r, red);
        chk("green", g, green);
        chk("blue", b, blue);
        chk("bypass", {7'h0, y}, {7'h0, byp});
    endtask
    task automatic io2(input logic wr, input logic [15:0] a,
        input logic [7:0] d, input logic [7:0] e);
        @(posedge sys_clk_in);
        link2.io_addr <= a;
        link2.io_wdata <= d;
        link2.io_wr <= wr;
        link2.io_rd <= !wr;
        @(posedge sys_clk_in);
        link2.io_wr <= 1'b0;
        link2.io_rd <= 1'b0;
        link2.io_addr <= ~a;
        #1;
        if (!wr)
            chk("io_rdata", e, link2.io_rdata);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_unlock();
        int i;
        for (i = 0; i < 3; i++)
            io2(1'b0, PIXEL_MASK_PORT, 8'h00, MASK_RESET);
        io2(1'b0, 16'h03C7, 8'h00, 8'h00);
        io2(1'b0, PIXEL_MASK_PORT, 8'h00, MASK_RESET);
        io2(1'b1, PIXEL_MASK_PORT, 8'hE1, 8'h00);
        chk("mode after broken run", 8'h00, mode2);
        for (i = 0; i < 4; i++)
            io2(1'b0, PIXEL_MASK_PORT, 8'h00, 8'hE1);
        io2(1'b1, PIXEL_MASK_PORT, 8'hE5, 8'h00);
        chk("mode after unlock", 8'hE5, mode2);
        for (i = 0; i < 5; i++)
            io2(1'b0, PIXEL_MASK_PORT, 8'h00, i < 4 ? 8'hE1 : 8'hE5);
        io2(1'b0, PIXEL_MASK_PORT, 8'h00, 8'hE1);
    endtask
    task automatic test_direct();
        logic [15:0] w;
        w = 16'hDAA5;
        set_mode(8'hE0);
        send({8'h00, w}, 2);
        rgb({w[14:10], 3'h0}, {w[9:5], 3'h0}, {w[4:0], 3'h0}, 1'b1);
        set_mode(8'hC0);
        send({8'h00, w}, 2);
        rgb({w[14:10], 3'h0}, {w[9:5], 3'h0}, {w[4:0], 3'h0}, 1'b1);
        set_mode(8'hF0);
        send(24'h005AA5, 2);
        rgb({w[14:10], 3'h0}, {w[9:5], 3'h0}, {w[4:0], 3'h0}, 1'b1);
        set_mode(8'hD0);
        send({8'h00, w}, 2);
        chk("bypass", 8'h00, {7'h0, byp});
        chk("index", w[7:0], idx);
        set_mode(8'hE1);
        send({8'h00, w}, 2);
        rgb({w[15:11], 3'h0}, {w[10:5], 2'h0}, {w[4:0], 3'h0}, 1'b1);
        set_mode(8'hE5);
        send(24'h123456, 3);
        rgb(8'h12, 8'h34, 8'h56, 1'b1);
    endtask
    task automatic test_narrow();
        logic [7:0] b;
        b = 8'h9C;
        set_mode(8'hC8);
        send({16'h0000, b}, 1);
        rgb(b, b, b, 1'b1);
        set_mode(8'hC9);
        send({16'h0000, b}, 1);
        rgb({b[7:5], 5'h00}, {b[4:2], 5'h00}, {b[1:0], 6'h00}, 1'b1);
        set_mode(8'hC6);
        chk("power down", 8'h01, {7'h0, pdn});
        rgb(8'h00, 8'h00, 8'h00, 1'b1);
    endtask
    task automatic test_mask();
        logic [7:0] q;
        cmd(1'b1, HOST_MASK, 8'h0F, q);
        set_mode(8'h00);
        cmd(1'b0, HOST_LAST_READ, 8'h00, q);
        chk("last mask read", 8'h0F, q);
        send(24'h0000A5, 1);
        chk("bypass", 8'h00, {7'h0, byp});
        chk("index", 8'h05, idx);
    endtask
    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    initial
    begin
        mismatches = 0;
        num_checks = 0;
        reset_n_in = 1'b0;
        {cmd_wr, cmd_rd, blank_n, cmd_addr, cmd_wdata, pix} = '0;
        {link2.io_wr, link2.io_rd, link2.io_addr, link2.io_wdata} = '0;
        {link2.pix_data, link2.pix_blank_n} = '0;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        #1 chk("reset mode", MODE_RESET, mode);
        chk("reset bypass", 8'h00, {7'h0, byp});
        test_unlock();
        test_direct();
        test_narrow();
        test_mask();
        stop_test();
    end
endmodule
`default_nettype wire
